// ---- rtl/psrl_regs.vh ----
/*
  psrl_regs.vh: constants for the pll serial ratio load block:
  frame lengths, field positions, apb offsets, reset values.
  assumes: included by its bare name from the design file.
*/
`ifndef PSRL_REGS_VH
`define PSRL_REGS_VH

// frame lengths in serial bits, selector included
`define PSRL_MAIN_FRAME_LEN 19
`define PSRL_REF_FRAME_LEN 15

// field widths
`define PSRL_SWALLOW_W 6
`define PSRL_MAIN_COUNT_W 12
`define PSRL_REF_W 14

// selector values
`define PSRL_SEL_MAIN 1'b0
`define PSRL_SEL_REF 1'b1

// least legal ratios
`define PSRL_MAIN_COUNT_MIN 12'h0005
`define PSRL_REF_MIN 14'h0005

// apb byte offsets
`define PSRL_MAIN_RATIO_OFS 12'h000
`define PSRL_REF_RATIO_OFS 12'h004
`define PSRL_STATUS_OFS 12'h008
`define PSRL_CTRL_OFS 12'h00C

// status bit positions
`define PSRL_ST_MAIN_LOADED 0
`define PSRL_ST_REF_LOADED 1
`define PSRL_ST_MAIN_BAD 2
`define PSRL_ST_REF_BAD 3
`define PSRL_ST_BITS_LO 8

// ctrl bit positions
`define PSRL_CTRL_ENABLE 0

// reset values
`define PSRL_CTRL_RESET 32'h0000_0001
`define PSRL_RATIO_RESET 32'h0000_0000

`endif

// ---- rtl/psrl_ratio_load.v ----
/*
  psrl_ratio_load.v: three-wire serial loader for the main and reference
  divider ratios of a pll synthesizer, with an apb view of the latches.
  assumes: serial pins come from another domain and are slow next to
  pclk (each level held well over two pclk periods); apb master on pclk.
*/
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "psrl_regs.vh"

module psrl_ratio_load (
  // clock and reset
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // serial pins
  input wire serial_data,
  input wire serial_clock,
  input wire load_strobe,
  // latched ratios
  output reg [`PSRL_SWALLOW_W-1:0] swallow_count_bits,
  output reg [`PSRL_MAIN_COUNT_W-1:0] main_count_bits,
  output reg [`PSRL_REF_W-1:0] reference_ratio_bits,
  output reg main_load_pulse,
  output reg ref_load_pulse
);

////////////////////////////////////////////////////////////////////////
// pin synchronisers; first stage read only by second stage

wire data_s;
wire sclk_s;
wire strobe_s;

psrl_sync2 #(
  .WIDTH(1)
) psrl_sync2_data_i (
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .async_in(serial_data),
  .sync_out(data_s)
);

psrl_sync2 #(
  .WIDTH(1)
) psrl_sync2_sclk_i (
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .async_in(serial_clock),
  .sync_out(sclk_s)
);

psrl_sync2 #(
  .WIDTH(1)
) psrl_sync2_strobe_i (
  .pclk(pclk),
  .presetn(presetn),
  .clk_en(clk_en),
  .async_in(load_strobe),
  .sync_out(strobe_s)
);

////////////////////////////////////////////////////////////////////////
// edge detectors; previous levels reset low, the idle level of both
// pins, so no false edge follows reset

reg sclk_d_r;
reg strobe_d_r;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    sclk_d_r <= 1'b0;
    strobe_d_r <= 1'b0;
  end
  else if (clk_en)
  begin
    sclk_d_r <= sclk_s;
    strobe_d_r <= strobe_s;
  end
end

wire sclk_rise = sclk_s & ~sclk_d_r;
wire strobe_rise = strobe_s & ~strobe_d_r;

////////////////////////////////////////////////////////////////////////
// control register

reg ctrl_enable_r;
wire wr_acc = psel & penable & pwrite;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    ctrl_enable_r <= 1'b1;
  else if (clk_en && wr_acc && paddr == `PSRL_CTRL_OFS)
    ctrl_enable_r <= pwdata[`PSRL_CTRL_ENABLE];
end

////////////////////////////////////////////////////////////////////////
// shift register: 18 ratio bits plus selector at the newest end.
// the newest bit is the selector, the bits before it the ratio, so older
// overflow simply falls off the far end.

reg [`PSRL_MAIN_FRAME_LEN-1:0] shift_r;
reg [`PSRL_MAIN_FRAME_LEN-1:0] shift_nxt;
reg [5:0] bit_cnt_r;
reg [5:0] bit_cnt_nxt;
wire shift_go = clk_en & ctrl_enable_r;

always @*
begin
  shift_nxt = shift_r;
  if (sclk_rise)
    shift_nxt = {shift_r[`PSRL_MAIN_FRAME_LEN-2:0], data_s};
end

// counter saturates so a runaway clock cannot wrap to a small count;
// a serial clock edge in the strobe cycle wins over the clear
always @*
begin
  bit_cnt_nxt = bit_cnt_r;
  if (sclk_rise)
  begin
    if (bit_cnt_r != 6'h3F)
      bit_cnt_nxt = bit_cnt_r + 6'h01;
  end
  else if (strobe_rise)
    bit_cnt_nxt = 6'h00;
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    shift_r <= 19'h0_0000;
    bit_cnt_r <= 6'h00;
  end
  else if (shift_go)
  begin
    shift_r <= shift_nxt;
    bit_cnt_r <= bit_cnt_nxt;
  end
end

// selector is the final bit shifted before the strobe
wire sel_bit = shift_r[0];
// ratio bits: msb first on the wire, so the lowest ratio bit is shift_r[1]
wire [`PSRL_MAIN_FRAME_LEN-2:0] main_word = shift_r[`PSRL_MAIN_FRAME_LEN-1:1];
wire [`PSRL_REF_W-1:0] ref_word = shift_r[`PSRL_REF_W:1];

////////////////////////////////////////////////////////////////////////
// latches: strobe anded with selector enables only one divider

wire main_en = strobe_rise & (sel_bit == `PSRL_SEL_MAIN);
wire ref_en = strobe_rise & (sel_bit == `PSRL_SEL_REF);

reg main_loaded_r;
reg ref_loaded_r;

// each divider latch sits in its own process, so one load cannot touch
// the other divider's ratio
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    swallow_count_bits <= 6'h00;
    main_count_bits <= 12'h000;
    main_load_pulse <= 1'b0;
    main_loaded_r <= 1'b0;
  end
  else if (clk_en)
  begin
    main_load_pulse <= 1'b0;
    if (ctrl_enable_r && main_en)
    begin
      swallow_count_bits <= main_word[`PSRL_SWALLOW_W-1:0];
      main_count_bits <= main_word[`PSRL_MAIN_FRAME_LEN-2:`PSRL_SWALLOW_W];
      main_load_pulse <= 1'b1;
      main_loaded_r <= 1'b1;
    end
  end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    reference_ratio_bits <= 14'h0000;
    ref_load_pulse <= 1'b0;
    ref_loaded_r <= 1'b0;
  end
  else if (clk_en)
  begin
    ref_load_pulse <= 1'b0;
    if (ctrl_enable_r && ref_en)
    begin
      reference_ratio_bits <= ref_word;
      ref_load_pulse <= 1'b1;
      ref_loaded_r <= 1'b1;
    end
  end
end

// range checks are flagged only; illegal values are still latched
wire main_bad = main_count_bits < `PSRL_MAIN_COUNT_MIN;
wire ref_bad = reference_ratio_bits < `PSRL_REF_MIN;

////////////////////////////////////////////////////////////////////////
// apb read; zero wait states, unmapped reads zero with error

reg [31:0] status_word;
reg [31:0] rd_nxt;
reg hit;

always @*
begin
  status_word = 32'h0000_0000;
  status_word[`PSRL_ST_MAIN_LOADED] = main_loaded_r;
  status_word[`PSRL_ST_REF_LOADED] = ref_loaded_r;
  status_word[`PSRL_ST_MAIN_BAD] = main_bad;
  status_word[`PSRL_ST_REF_BAD] = ref_bad;
  status_word[`PSRL_ST_BITS_LO+5:`PSRL_ST_BITS_LO] = bit_cnt_r;
end

always @*
begin
  rd_nxt = 32'h0000_0000;
  hit = 1'b1;
  case (paddr)
    `PSRL_MAIN_RATIO_OFS: rd_nxt = {14'h0000, main_count_bits, swallow_count_bits};
    `PSRL_REF_RATIO_OFS: rd_nxt = {18'h0_0000, reference_ratio_bits};
    `PSRL_STATUS_OFS: rd_nxt = status_word;
    `PSRL_CTRL_OFS: rd_nxt = {31'h0000_0000, ctrl_enable_r};
    default: hit = 1'b0;
  endcase
end

assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    prdata <= 32'h0000_0000;
  else if (clk_en && psel && !penable && !pwrite)
    prdata <= rd_nxt;
end

endmodule // psrl_ratio_load

////////////////////////////////////////////////////////////////////////
// two flip-flop synchroniser for slow pin levels; the first stage may go
// metastable and is read by nothing but the second

module psrl_sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // pin side
  input wire [WIDTH-1:0] async_in,
  // clock side
  output wire [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] stage1_r;
reg [WIDTH-1:0] stage2_r;

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    stage1_r <= {WIDTH{1'b0}};
    stage2_r <= {WIDTH{1'b0}};
  end
  else if (clk_en)
  begin
    stage1_r <= async_in;
    stage2_r <= stage1_r;
  end
end

assign sync_out = stage2_r;

endmodule // psrl_sync2

// ---- verification/psrl_host_model.sv ----
/* host model: drives data, clock, strobe. assumes free pclk. */
`timescale 1ns/100ps
module psrl_host_model (
  // clock
  input wire pclk,
  // pins
  output logic serial_data,
  output logic serial_clock,
  output logic load_strobe
);
  initial {serial_data, serial_clock, load_strobe} = 3'b000;
  // levels held 4 pclk, the synchroniser needs 2
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // msb first, selector last, then strobe
  task automatic frame(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serial_data <= v[i];
      hold(4);
      serial_clock <= 1'b1;
      hold(4);
      serial_clock <= 1'b0;
      hold(4);
    end
    load_strobe <= 1'b1;
    hold(6);
    load_strobe <= 1'b0;
    serial_data <= ~serial_data;
    hold(8);
  endtask
endmodule // psrl_host_model

// ---- verification/psrl_ratio_load_asserts.sv ----
/* checker on loader ports. assumes bind below. */
`timescale 1ns/100ps
module psrl_ratio_load_asserts (
  // clock
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  // apb, to follow the enable bit
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // pins and latches
  input wire load_strobe,
  input wire [5:0] swallow_count_bits,
  input wire [11:0] main_count_bits,
  input wire [13:0] reference_ratio_bits,
  input wire main_load_pulse,
  input wire ref_load_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam logic [11:0] CTRL_ADDR = 12'h00C;
  logic en_r;
  always @(posedge pclk or negedge presetn)
    if (!presetn) en_r <= 1'b1;
    else if (clk_en && psel && penable && pwrite && paddr == CTRL_ADDR) en_r <= pwdata[0];
  property p_quiet; !en_r |=> !(main_load_pulse || ref_load_pulse); endproperty
  a_quiet: assert property (p_quiet) else $error("load while off");
  property p_excl; !(main_load_pulse && ref_load_pulse); endproperty
  a_excl: assert property (p_excl) else $error("two loads");
  property p_mhold; !main_load_pulse |-> $stable({main_count_bits, swallow_count_bits}); endproperty
  a_mhold: assert property (p_mhold) else $error("main moved");
  property p_rhold; !ref_load_pulse |-> $stable(reference_ratio_bits); endproperty
  a_rhold: assert property (p_rhold) else $error("ref moved");
  property p_mcause; main_load_pulse |-> $past(load_strobe, 3); endproperty
  a_mcause: assert property (p_mcause) else $error("main no strobe");
  property p_rcause; ref_load_pulse |-> $past(load_strobe, 3); endproperty
  a_rcause: assert property (p_rcause) else $error("ref no strobe");
  property p_load; en_r && $rose(load_strobe) |-> ##[3:6] (main_load_pulse || ref_load_pulse);
  endproperty
  a_load: assert property (p_load) else $error("no load");
  property p_mone; main_load_pulse |=> !main_load_pulse; endproperty
  a_mone: assert property (p_mone) else $error("main pulse long");
  property p_rone; ref_load_pulse |=> !ref_load_pulse; endproperty
  a_rone: assert property (p_rone) else $error("ref pulse long");
endmodule // psrl_ratio_load_asserts
bind psrl_ratio_load psrl_ratio_load_asserts psrl_ratio_load_asserts_i (.pclk(pclk),
  .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata),
  .load_strobe(load_strobe), .swallow_count_bits(swallow_count_bits),
  .main_count_bits(main_count_bits), .reference_ratio_bits(reference_ratio_bits),
  .main_load_pulse(main_load_pulse), .ref_load_pulse(ref_load_pulse));

// ---- verification/tb_top.sv ----
/* bench: apb reads and serial frames. assumes host model. */
`timescale 1ns/100ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e, ce = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  wire pready, pslverr, sd, sc, ls, mp, rp;
  wire [31:0] prdata;
  wire [5:0] sw;
  wire [11:0] mc;
  wire [13:0] rr;
  int failures = 0, checks = 0, cyc = 0;
  always #25 pclk = ~pclk;
  psrl_host_model psrl_host_model_i (.pclk(pclk), .serial_data(sd), .serial_clock(sc),
    .load_strobe(ls));
  psrl_ratio_load psrl_ratio_load_i (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .serial_data(sd),
    .serial_clock(sc), .load_strobe(ls), .swallow_count_bits(sw), .main_count_bits(mc),
    .reference_ratio_bits(rr), .main_load_pulse(mp), .ref_load_pulse(rp));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      $display("unexpected %s: expected %h seen %h", n, x, g);
      failures++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    psrl_host_model_i.frame({14'h0005, 1'b1}, 15);
    chk("ref", 14'h0005, rr);
    psrl_host_model_i.frame({3'b101, 12'h0123, 6'h2A, 1'b0}, 22);
    chk("count", 12'h0123, mc);
    chk("swallow", 6'h2A, sw);
    chk("ref kept", 14'h0005, rr);
    apb(1'b1, 12'h000, 32'h0000_0ABC);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("main word", {14'h0, 12'h0123, 6'h2A}, q);
    psrl_host_model_i.frame({2'b11, 14'h3FFF, 1'b1}, 17);
    chk("ref max", 14'h3FFF, rr);
    chk("count kept", 12'h0123, mc);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("ref word", 32'h0000_3FFF, q);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("status", 32'h0000_0003, q);
    ce <= 1'b0;
    apb(1'b1, 12'h00C, 32'h0000_0000);
    ce <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("frozen ctrl", 32'h0000_0001, q);
    apb(1'b1, 12'h00C, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("ctrl off", 32'h0000_0000, q);
    psrl_host_model_i.frame({14'h0009, 1'b1}, 15);
    chk("ref off", 14'h3FFF, rr);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("status off", 32'h0000_0003, q);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset ratios", 32'h0000_0000, {rr, mc, sw});
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("reset ctrl", 32'h0000_0001, q);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("reset status", 32'h0000_000C, q);
    summarize();
  end
endmodule // tb_top
